// [spw_regs.vh]
// Register map, field positions, reset values and event vector layout of the six-channel modulator
`ifndef SPW_REGS_VH
`define SPW_REGS_VH

// Word-aligned byte offsets
`define SPW_OFF_CTRL 8'h00
`define SPW_OFF_PRESC 8'h04
`define SPW_OFF_PERIOD 8'h08
`define SPW_OFF_DELAY 8'h0C
`define SPW_OFF_STATUS 8'h10
`define SPW_OFF_COUNT 8'h14
`define SPW_OFF_EVMASK 8'h18
`define SPW_OFF_TRAPLVL 8'h1C
`define SPW_OFF_CAPCFG 8'h20
`define SPW_OFF_CAP0 8'h24
`define SPW_OFF_CAP1 8'h28
`define SPW_OFF_CAP2 8'h2C
// Channel n rise at CHAN_BASE + 8*n, fall at CHAN_BASE + 8*n + 4
`define SPW_OFF_CHAN_BASE 8'h40

// Control register bits
`define SPW_CTRL_RUN 0
`define SPW_CTRL_ONCE 1
`define SPW_CTRL_SLAVE 2
`define SPW_CTRL_COMMIT 3
`define SPW_CTRL_BURST 4
`define SPW_CTRL_TRAPEN 5

// Status register bits
`define SPW_STAT_RUNNING 0
`define SPW_STAT_TRAP 1
`define SPW_STAT_PENDING 2

// Event vector layout
`define SPW_EV_MATCH 0
`define SPW_EV_CAP 6
`define SPW_EV_OVF 9
`define SPW_EV_TRAP 10
`define SPW_EV_W 11

// Reset values
`define SPW_RST_PRESC 16'h0000
`define SPW_RST_PERIOD 16'hFFFF
`define SPW_RST_DELAY 16'h0000
`define SPW_RST_EDGE 16'h0000
`define SPW_RST_CAPCFG 6'h07
`define SPW_RST_EVMASK 11'h000
`define SPW_RST_TRAPLVL 6'h00

`endif

// [spw_sync_pwm.v]
// Six-channel synchronisable pulse-width modulator with capture, trap and Avalon-MM registers
`timescale 1ns/1ps
`include "spw_regs.vh"

module spw_sync_pwm #(
  parameter CW = 16, // Counter width
  parameter NCH = 6, // Modulated outputs
  parameter NCAP = 3 // Capture inputs
) (
  input wire CLK_I,
  input wire RESET_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  input wire [NCAP-1:0] CAPTURE_PIN_I,
  input wire PROTECT_INPUT_PIN_I,
  input wire CARRIER_I,
  input wire SYNC_IN_I,
  input wire TRANS_EN_IN_I,
  output reg [NCH-1:0] MODULATED_OUTPUT_PIN_O,
  output reg SYNC_OUT_O,
  output reg TRANS_EN_OUT_O,
  output reg [`SPW_EV_W-1:0] EVENT_REQ_O
);

  // Merge a 32-bit write into a 16-bit register by byte enables
  function [15:0] spw_merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      spw_merge = old;
      if (be[0]) begin
        spw_merge[7:0] = wd[7:0];
      end
      if (be[1]) begin
        spw_merge[15:8] = wd[15:8];
      end
    end
  endfunction

  integer i; // Loop index of the counting process
  integer j; // Loop index of the output decode
  integer k; // Loop index of the staged register reset

  // Bus handshake state
  reg ack; // High in the completing cycle of an access
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire wr_en = AVS_WRITE_I & ack;
  reg [31:0] next_rdata;

  // Staged settings, written by software (bus side)
  reg run;
  reg once;
  reg slave;
  reg burst;
  reg trap_en;
  reg pending; // Staged settings waiting for shadow copy
  reg [CW-1:0] stg_presc;
  reg [CW-1:0] stg_period;
  reg [CW-1:0] stg_rise [0:NCH-1];
  reg [CW-1:0] stg_fall [0:NCH-1];
  reg [CW-1:0] sync_delay;
  reg [`SPW_EV_W-1:0] ev_mask;
  reg [NCH-1:0] trap_lvl;
  reg [2*NCAP-1:0] cap_cfg; // Low half rise enables, high half fall enables

  // Shadow settings, used by the counting side
  reg [CW-1:0] sh_presc;
  reg [CW-1:0] sh_period;
  reg [CW-1:0] sh_rise [0:NCH-1];
  reg [CW-1:0] sh_fall [0:NCH-1];

  // Counting side state
  reg running;
  reg [CW-1:0] pre_cnt;
  reg [CW-1:0] cnt;
  reg [NCH-1:0] pwm;
  reg trap_state;
  reg [CW-1:0] cap_val [0:NCAP-1];
  reg [CW-1:0] dly_cnt;
  reg dly_busy;
  reg dly_xfer;

  // Input synchronisers, third stage only for edge detection
  reg [NCAP-1:0] cap_s1;
  reg [NCAP-1:0] cap_s2;
  reg [NCAP-1:0] cap_s3;
  reg trap_s1;
  reg trap_s2;
  reg trap_s3;

  // Per-channel register decode
  wire chan_hit = (AVS_ADDRESS_I[7:6] == 2'b01) && (AVS_ADDRESS_I[5:3] < NCH);
  wire [2:0] chan_idx = AVS_ADDRESS_I[5:3];
  wire chan_fall = AVS_ADDRESS_I[2];

  // Counting control terms
  wire tick = running && (pre_cnt == sh_presc);
  wire per_end = tick && (cnt == sh_period);
  wire start_m = !slave && run && !running;
  wire sync_hit = slave && run && SYNC_IN_I;
  wire restart = start_m || sync_hit || (per_end && !once);
  wire once_done = per_end && once && !sync_hit;
  wire xfer = slave ? (run && TRANS_EN_IN_I) : (restart && pending);
  wire adv = restart || (tick && !per_end);
  wire [CW-1:0] nc = restart ? {CW{1'b0}} : cnt + {{(CW-1){1'b0}}, 1'b1};
  wire trap_ev = trap_en && trap_s2 && !trap_s3;
  wire trap_clr = wr_en && (AVS_ADDRESS_I == `SPW_OFF_STATUS) && AVS_BYTEENABLE_I[0]
                  && AVS_WRITEDATA_I[`SPW_STAT_TRAP];
  wire [NCAP-1:0] cap_ev = (cap_s2 & ~cap_s3 & cap_cfg[NCAP-1:0])
                         | (~cap_s2 & cap_s3 & cap_cfg[2*NCAP-1:NCAP]);
  reg [NCH-1:0] match_ev;
  reg [NCH-1:0] next_pwm;

  // Waitrequest drops for exactly one cycle per access
  assign AVS_WAITREQUEST_O = req & ~ack;

  // Handshake and read data register
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      ack <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (AVS_READ_I && !ack) begin
        AVS_READDATA_O <= next_rdata;
      end
    end
  end

  // Read multiplexer, unmapped offsets read zero
  always @* begin
    next_rdata = 32'h00000000;
    if (chan_hit) begin
      next_rdata[CW-1:0] = chan_fall ? stg_fall[chan_idx] : stg_rise[chan_idx];
    end else begin
      case (AVS_ADDRESS_I)
        `SPW_OFF_CTRL: begin
          next_rdata[`SPW_CTRL_RUN] = run;
          next_rdata[`SPW_CTRL_ONCE] = once;
          next_rdata[`SPW_CTRL_SLAVE] = slave;
          next_rdata[`SPW_CTRL_BURST] = burst;
          next_rdata[`SPW_CTRL_TRAPEN] = trap_en;
        end
        `SPW_OFF_PRESC: next_rdata[CW-1:0] = stg_presc;
        `SPW_OFF_PERIOD: next_rdata[CW-1:0] = stg_period;
        `SPW_OFF_DELAY: next_rdata[CW-1:0] = sync_delay;
        `SPW_OFF_STATUS: begin
          next_rdata[`SPW_STAT_RUNNING] = running;
          next_rdata[`SPW_STAT_TRAP] = trap_state;
          next_rdata[`SPW_STAT_PENDING] = pending;
        end
        `SPW_OFF_COUNT: next_rdata[CW-1:0] = cnt;
        `SPW_OFF_EVMASK: next_rdata[`SPW_EV_W-1:0] = ev_mask;
        `SPW_OFF_TRAPLVL: next_rdata[NCH-1:0] = trap_lvl;
        `SPW_OFF_CAPCFG: next_rdata[2*NCAP-1:0] = cap_cfg;
        `SPW_OFF_CAP0: next_rdata[CW-1:0] = cap_val[0];
        `SPW_OFF_CAP1: next_rdata[CW-1:0] = cap_val[1];
        `SPW_OFF_CAP2: next_rdata[CW-1:0] = cap_val[2];
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Staged register writes, hardware clears of run and pending
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      run <= 1'b0;
      once <= 1'b0;
      slave <= 1'b0;
      burst <= 1'b0;
      trap_en <= 1'b0;
      pending <= 1'b0;
      stg_presc <= `SPW_RST_PRESC;
      stg_period <= `SPW_RST_PERIOD;
      sync_delay <= `SPW_RST_DELAY;
      ev_mask <= `SPW_RST_EVMASK;
      trap_lvl <= `SPW_RST_TRAPLVL;
      cap_cfg <= `SPW_RST_CAPCFG;
      for (k = 0; k < NCH; k = k + 1) begin
        stg_rise[k] <= `SPW_RST_EDGE;
        stg_fall[k] <= `SPW_RST_EDGE;
      end
    end else begin
      // Shadow copy consumes the pending request
      if (xfer) begin
        pending <= 1'b0;
      end
      // Run-once end stops the counter
      if (once_done) begin
        run <= 1'b0;
      end
      // Software writes come last so a set beats a hardware clear
      if (wr_en && chan_hit) begin
        if (chan_fall) begin
          stg_fall[chan_idx] <= spw_merge(stg_fall[chan_idx], AVS_WRITEDATA_I,
                                          AVS_BYTEENABLE_I);
        end else begin
          stg_rise[chan_idx] <= spw_merge(stg_rise[chan_idx], AVS_WRITEDATA_I,
                                          AVS_BYTEENABLE_I);
        end
      end else if (wr_en) begin
        case (AVS_ADDRESS_I)
          `SPW_OFF_CTRL: begin
            if (AVS_BYTEENABLE_I[0]) begin
              run <= AVS_WRITEDATA_I[`SPW_CTRL_RUN];
              once <= AVS_WRITEDATA_I[`SPW_CTRL_ONCE];
              slave <= AVS_WRITEDATA_I[`SPW_CTRL_SLAVE];
              burst <= AVS_WRITEDATA_I[`SPW_CTRL_BURST];
              trap_en <= AVS_WRITEDATA_I[`SPW_CTRL_TRAPEN];
              if (AVS_WRITEDATA_I[`SPW_CTRL_COMMIT]) begin
                pending <= 1'b1;
              end
            end
          end
          `SPW_OFF_PRESC: stg_presc <= spw_merge(stg_presc, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `SPW_OFF_PERIOD: stg_period <= spw_merge(stg_period, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `SPW_OFF_DELAY: sync_delay <= spw_merge(sync_delay, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `SPW_OFF_EVMASK: begin
            if (AVS_BYTEENABLE_I[0]) begin
              ev_mask[7:0] <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_BYTEENABLE_I[1]) begin
              ev_mask[`SPW_EV_W-1:8] <= AVS_WRITEDATA_I[`SPW_EV_W-1:8];
            end
          end
          `SPW_OFF_TRAPLVL: begin
            if (AVS_BYTEENABLE_I[0]) begin
              trap_lvl <= AVS_WRITEDATA_I[NCH-1:0];
            end
          end
          `SPW_OFF_CAPCFG: begin
            if (AVS_BYTEENABLE_I[0]) begin
              cap_cfg <= AVS_WRITEDATA_I[2*NCAP-1:0];
            end
          end
          default: begin
            // Read-only or unmapped offset, write ignored
          end
        endcase
      end
    end
  end

  // Two-stage synchronisers plus an edge-detect stage
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      cap_s1 <= {NCAP{1'b0}};
      cap_s2 <= {NCAP{1'b0}};
      cap_s3 <= {NCAP{1'b0}};
      trap_s1 <= 1'b0;
      trap_s2 <= 1'b0;
      trap_s3 <= 1'b0;
    end else begin
      cap_s1 <= CAPTURE_PIN_I;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      trap_s1 <= PROTECT_INPUT_PIN_I;
      trap_s2 <= trap_s1;
      trap_s3 <= trap_s2;
    end
  end

  // Next output levels and match events at each counter advance
  always @* begin
    next_pwm = pwm;
    match_ev = {NCH{1'b0}};
    for (j = 0; j < NCH; j = j + 1) begin
      if (adv && nc == sh_fall[j]) begin
        next_pwm[j] = 1'b0;
        match_ev[j] = 1'b1;
      end else if (adv && nc == sh_rise[j]) begin
        next_pwm[j] = 1'b1;
        match_ev[j] = 1'b1;
      end
    end
    if (!run) begin
      next_pwm = {NCH{1'b0}};
    end
  end

  // Prescaler, period counter, shadow copy, trap and capture
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      running <= 1'b0;
      pre_cnt <= {CW{1'b0}};
      cnt <= {CW{1'b0}};
      pwm <= {NCH{1'b0}};
      trap_state <= 1'b0;
      sh_presc <= `SPW_RST_PRESC;
      sh_period <= `SPW_RST_PERIOD;
      for (i = 0; i < NCH; i = i + 1) begin
        sh_rise[i] <= `SPW_RST_EDGE;
        sh_fall[i] <= `SPW_RST_EDGE;
      end
      for (i = 0; i < NCAP; i = i + 1) begin
        cap_val[i] <= {CW{1'b0}};
      end
    end else begin
      pwm <= next_pwm;
      // Counter sequencing, all in module clock cycles
      if (!run) begin
        running <= 1'b0;
        pre_cnt <= {CW{1'b0}};
        cnt <= {CW{1'b0}};
      end else if (restart) begin
        running <= 1'b1;
        pre_cnt <= {CW{1'b0}};
        cnt <= {CW{1'b0}};
      end else if (once_done) begin
        running <= 1'b0;
      end else if (tick) begin
        pre_cnt <= {CW{1'b0}};
        cnt <= nc;
      end else if (running) begin
        pre_cnt <= pre_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      // Staged settings into shadow copies at the transfer point
      if (xfer) begin
        sh_presc <= stg_presc;
        sh_period <= stg_period;
        for (i = 0; i < NCH; i = i + 1) begin
          sh_rise[i] <= stg_rise[i];
          sh_fall[i] <= stg_fall[i];
        end
      end
      // Trap latches until software clears it, event wins
      if (trap_ev) begin
        trap_state <= 1'b1;
      end else if (trap_clr) begin
        trap_state <= 1'b0;
      end
      // Capture the period counter on selected edges
      for (i = 0; i < NCAP; i = i + 1) begin
        if (cap_ev[i]) begin
          cap_val[i] <= cnt;
        end
      end
    end
  end

  // Delayed sync-out and transfer-out pulses for the next module
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      dly_cnt <= {CW{1'b0}};
      dly_busy <= 1'b0;
      dly_xfer <= 1'b0;
      SYNC_OUT_O <= 1'b0;
      TRANS_EN_OUT_O <= 1'b0;
    end else begin
      SYNC_OUT_O <= 1'b0;
      TRANS_EN_OUT_O <= 1'b0;
      if (restart) begin
        dly_cnt <= sync_delay;
        dly_busy <= 1'b1;
        dly_xfer <= xfer;
      end else if (dly_busy) begin
        if (dly_cnt == {CW{1'b0}}) begin
          dly_busy <= 1'b0;
          SYNC_OUT_O <= 1'b1;
          TRANS_EN_OUT_O <= dly_xfer;
        end else begin
          dly_cnt <= dly_cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Output stage: trap levels, burst gating, event requests
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      MODULATED_OUTPUT_PIN_O <= {NCH{1'b0}};
      EVENT_REQ_O <= {`SPW_EV_W{1'b0}};
    end else begin
      if (trap_state) begin
        MODULATED_OUTPUT_PIN_O <= trap_lvl;
      end else if (burst) begin
        MODULATED_OUTPUT_PIN_O <= pwm & {NCH{CARRIER_I}};
      end else begin
        MODULATED_OUTPUT_PIN_O <= pwm;
      end
      EVENT_REQ_O <= {trap_ev, per_end, cap_ev, match_ev} & ev_mask;
    end
  end

endmodule // spw_sync_pwm

// [spw_sync_pwm_sva.sv]
// Checker for the six-channel modulator ports
`timescale 1ns/1ps
`include "spw_regs.vh"

module spw_sync_pwm_sva #(
  parameter NCH = 6, // Modulated outputs
  parameter NCAP = 3 // Capture inputs
) (
  input wire CLK_I,
  input wire RESET_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  input wire [NCAP-1:0] CAPTURE_PIN_I,
  input wire PROTECT_INPUT_PIN_I,
  input wire [NCH-1:0] MODULATED_OUTPUT_PIN_O,
  input wire SYNC_OUT_O,
  input wire TRANS_EN_OUT_O,
  input wire [`SPW_EV_W-1:0] EVENT_REQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Request presented and still stalled
  sequence s_req_wait;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  // No read being accepted into the data register
  sequence s_no_load;
    !(AVS_READ_I && AVS_WAITREQUEST_O);
  endsequence
  AST_WAIT_ONE: assert property (s_req_wait |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest stayed high");
  AST_WAIT_CAUSE: assert property (AVS_WAITREQUEST_O |-> AVS_READ_I || AVS_WRITE_I)
    else $error("waitrequest without request");
  AST_RD_HOLD: assert property (s_no_load |=> $stable(AVS_READDATA_O))
    else $error("read data moved without read");
  AST_SYNC_ONE: assert property (SYNC_OUT_O |=> !SYNC_OUT_O)
    else $error("sync out longer than one cycle");
  AST_TRANS_ALIGN: assert property (TRANS_EN_OUT_O |-> SYNC_OUT_O)
    else $error("transfer out not with sync out");
  AST_RESET_OUTS: assert property (disable iff (1'b0) RESET_I |=>
    MODULATED_OUTPUT_PIN_O == 0 && !SYNC_OUT_O && EVENT_REQ_O == 0)
    else $error("outputs active after reset");
  AST_CAP_CAUSE: assert property (EVENT_REQ_O[8:6] != 0 |->
    $past(CAPTURE_PIN_I, 1) != $past(CAPTURE_PIN_I, 6))
    else $error("capture event without pin edge");
  AST_TRAP_CAUSE: assert property (EVENT_REQ_O[10] |-> $past(PROTECT_INPUT_PIN_I, 2))
    else $error("trap event without trap pin");
endmodule // spw_sync_pwm_sva

bind spw_sync_pwm spw_sync_pwm_sva #(.NCH(NCH), .NCAP(NCAP)) i_spw_sync_pwm_sva (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CAPTURE_PIN_I(CAPTURE_PIN_I),
  .PROTECT_INPUT_PIN_I(PROTECT_INPUT_PIN_I), .MODULATED_OUTPUT_PIN_O(MODULATED_OUTPUT_PIN_O),
  .SYNC_OUT_O(SYNC_OUT_O), .TRANS_EN_OUT_O(TRANS_EN_OUT_O), .EVENT_REQ_O(EVENT_REQ_O));

// [spw_nbr_model.sv]
// Neighbouring master modulator and external pins
`timescale 1ns/1ps

module spw_nbr_model (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic xfer_i,
  input wire logic [2:0] cap_i,
  input wire logic trap_i,
  output logic sync_o,
  output logic trans_o,
  output logic [2:0] cap_pin_o,
  output logic trap_pin_o,
  output logic carrier_o
);
  initial begin
    sync_o = 1'b0;
    trans_o = 1'b0;
    cap_pin_o = 3'h0;
    trap_pin_o = 1'b0;
    carrier_o = 1'b0;
  end
  // One-cycle restart pulse, transfer pulse aligned with it
  always @(posedge clk_i) begin
    sync_o <= fire_i;
    trans_o <= fire_i & xfer_i;
    cap_pin_o <= cap_i;
    trap_pin_o <= trap_i;
    carrier_o <= ~carrier_o;
  end
endmodule // spw_nbr_model

// [test_sync_pwm_six_channel.sv]
// Self-checking bench for the six-channel modulator
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

module test_sync_pwm_six_channel;
  logic clk = 0, rst = 1, rd = 0, wr = 0, fire = 0, xfer = 0, trap = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [2:0] cap = 3'h0, cap_pin;
  logic wreq, sync_in, trans_in, trap_pin, carrier, sync_out, trans_out;
  logic [5:0] pwm;
  logic [10:0] ev, evs = 0;
  int failures = 0, checked = 0, cyc = 0, nsync = 0, ntrans = 0, nhigh = 0, s0, s1, s2;
  // Register reset table: offset, expected value
  logic [7:0] ra [9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
  logic [31:0] rv [9] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0};

  always #2.5 clk = ~clk;

  spw_sync_pwm i_spw_sync_pwm (.CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .CAPTURE_PIN_I(cap_pin),
    .PROTECT_INPUT_PIN_I(trap_pin), .CARRIER_I(carrier), .SYNC_IN_I(sync_in),
    .TRANS_EN_IN_I(trans_in), .MODULATED_OUTPUT_PIN_O(pwm), .SYNC_OUT_O(sync_out),
    .TRANS_EN_OUT_O(trans_out), .EVENT_REQ_O(ev));

  spw_nbr_model i_spw_nbr_model (.clk_i(clk), .fire_i(fire), .xfer_i(xfer), .cap_i(cap),
    .trap_i(trap), .sync_o(sync_in), .trans_o(trans_in), .cap_pin_o(cap_pin),
    .trap_pin_o(trap_pin), .carrier_o(carrier));

  // Monitor on the falling edge, where outputs are settled
  always @(negedge clk) begin
    if (!rst) begin
      nsync += (sync_out === 1'b1);
      ntrans += (trans_out === 1'b1 && sync_out === 1'b1);
      nhigh += (pwm[0] === 1'b1);
      evs |= ev;
    end
  end

  // Watchdog cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hold request until waitrequest seen low at a rising edge
  task bus_wait();
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
  endtask

  task bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    bus_wait();
    wr <= 1'b0;
  endtask

  task br(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    bus_wait();
    got = rdata;
    rd <= 1'b0;
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    wait_n(4);
    rst <= 1'b0;
    // Reset values, unmapped offset reads zero
    for (int i = 0; i < 9; i++) begin
      br(ra[i]);
      `CHK(got, rv[i])
    end
    // Read-only count ignores writes
    bw(8'h14, 32'h1234);
    br(8'h14);
    `CHK(got, 32'h0)
    // Master run: step 2 clocks, period 10 steps, channel 0 high 2..5
    bw(8'h04, 32'h1);
    bw(8'h08, 32'h9);
    bw(8'h40, 32'h2);
    bw(8'h44, 32'h5);
    bw(8'h0C, 32'h2);
    bw(8'h18, 32'h7FF);
    bw(8'h00, 32'h9);
    @(negedge clk);
    s0 = nsync;
    s1 = ntrans;
    s2 = nhigh;
    evs = 0;
    repeat (100) @(negedge clk);
    `CHK(nsync - s0, 5)
    `CHK(ntrans - s1, 1)
    `CHK(nhigh - s2, 30)
    `CHK({evs[9], evs[0]}, 2'b11)
    // Capture on input 1 while running, counter is 1 when the edge lands
    wait_n(1);
    cap <= 3'b010;
    wait_n(8);
    cap <= 3'b000;
    wait_n(4);
    br(8'h28);
    `CHK(got, 32'h1)
    `CHK(evs[8:6], 3'b010)
    // Slave: restarts every 4 clocks keep the period end away
    bw(8'h00, 32'hD);
    br(8'h10);
    `CHK(got[2], 1'b1)
    for (int i = 0; i < 12; i++) begin
      fire <= 1'b1;
      xfer <= (i == 11);
      wait_n(1);
      fire <= 1'b0;
      wait_n(3);
      if (i == 0) evs = 0;
    end
    `CHK(evs[9], 1'b0)
    // Transfer-enable pulse consumed the pending commit
    br(8'h10);
    `CHK(got[2], 1'b0)
    // Run-once stops after one period
    bw(8'h00, 32'h0);
    s0 = nsync;
    bw(8'h00, 32'h3);
    wait_n(60);
    br(8'h10);
    `CHK(got[0], 1'b0)
    `CHK(nsync - s0, 1)
    // Trap forces software levels until cleared
    bw(8'h1C, 32'h2A);
    bw(8'h00, 32'h21);
    trap <= 1'b1;
    wait_n(8);
    `CHK(pwm, 6'h2A)
    br(8'h10);
    `CHK({got[1], evs[10]}, 2'b11)
    trap <= 1'b0;
    bw(8'h10, 32'h2);
    br(8'h10);
    `CHK(got[1], 1'b0)
    // Burst: carrier toggles each clock, halving each 6-cycle pulse
    bw(8'h00, 32'h11);
    repeat (2) @(negedge clk);
    s2 = nhigh;
    repeat (100) @(negedge clk);
    `CHK(nhigh - s2, 15)
    wait_n(1);
    // Second reset in mid-run restores defaults
    rst <= 1'b1;
    wait_n(4);
    rst <= 1'b0;
    `CHK(pwm, 6'h00)
    br(8'h08);
    `CHK(got, 32'hFFFF)
    final_report();
  end
endmodule // test_sync_pwm_six_channel
